// ---- efst_pkg.sv ----
// Shared constants, encodings and carrier types of the earth-fault stage timer.
package efst_pkg;
  // ==========================================================================
  // Sizes and timebase
  // ==========================================================================
  localparam int NSTG = 4;
  localparam int SW = 16;
  localparam int MW = 18;
  localparam int CLK_HZ = 40_000_000;
  localparam int TICK_US = 1000;
  localparam int TICK_CYC = CLK_HZ / 1_000_000 * TICK_US;
  localparam logic [31:0] PEAK_STEP_MS = 32'h0000_0014;
  localparam int FORCE_TIMEOUT_MIN = 5;
  localparam logic [31:0] FORCE_TIMEOUT_MS = 32'(FORCE_TIMEOUT_MIN * 60 * 1000);
  localparam int RES_SAT_X = 10;
  localparam int PH_SAT_X = 50;
  localparam int DFT_SHIFT = 10;
  // ==========================================================================
  // Register map, word indices at address bits 5:2; bits 7:6 pick the stage, bit 8 selects the global page
  // ==========================================================================
  localparam logic [3:0] IX_CTRL = 4'h0;
  localparam logic [3:0] IX_PICK1 = 4'h1;
  localparam logic [3:0] IX_DLY1 = 4'h2;
  localparam logic [3:0] IX_PICK2 = 4'h3;
  localparam logic [3:0] IX_DLY2 = 4'h4;
  localparam logic [3:0] IX_INTRMT = 4'h5;
  localparam logic [3:0] IX_STATUS = 4'h6;
  localparam logic [3:0] IX_REMAIN = 4'h7;
  localparam logic [3:0] IX_STALLY = 4'h8;
  localparam logic [3:0] IX_TTALLY = 4'h9;
  localparam logic [3:0] IX_PRIM = 4'hA;
  localparam logic [3:0] IX_GROUP = 4'hB;
  localparam logic [3:0] IX_FSTAT = 4'hC;
  localparam logic [3:0] IX_GFORCE = 4'h0;
  localparam logic [3:0] IX_GRATIO_RES = 4'h1;
  localparam logic [3:0] IX_GRATIO_PH = 4'h2;
  localparam logic [15:0] PICK_RST = 16'hFFFF;
  localparam logic [15:0] DLY_RST = 16'h0064;
  localparam logic [15:0] RATIO_RST = 16'h0001;
  // ==========================================================================
  // Encodings and carriers
  // ==========================================================================
  typedef enum logic [2:0] {
    SRC_CH1 = 3'b000, SRC_CH2 = 3'b001, SRC_CALC = 3'b010,
    SRC_CALC2 = 3'b011, SRC_PK1 = 3'b100, SRC_PK2 = 3'b101
  } efst_src_t;
  typedef enum logic [1:0] {
    ST_IDLE = 2'b00, ST_BLOCKED = 2'b01, ST_STARTED = 2'b10, ST_TRIPPED = 2'b11
  } efst_state_t;
  typedef struct packed {
    logic inverse;
    logic peak;
    logic [15:0] pickup;
    logic [15:0] delay;
    logic [15:0] intrmt;
  } efst_set_t;
  typedef struct packed {
    logic start;
    logic trip;
    efst_state_t state;
    logic [31:0] remain;
  } efst_stat_t;
endpackage

// ---- efst_fund.sv ----
// One-cycle DFT that extracts the fundamental magnitude of a sampled current.
`timescale 1ns/10ps
module efst_fund
  import efst_pkg::*;
#(
  parameter int W = MW
) (
  input wire logic clk_i,
  input wire logic rst_i,
  input wire logic stb_i,
  input wire logic signed [W-1:0] x_i,
  output logic [W-1:0] mag_o
);
  // ==========================================================================
  // Sixteen samples per cycle correlate against a cosine table. A whole-cycle
  // DFT has nulls at every harmonic from 2 to 14, so the third harmonic is
  // rejected by over 50 dB; the price is one result per mains cycle.
  // ==========================================================================
  localparam int AW = W + 13;
  localparam logic signed [7:0] COS_T [16] = '{
    8'sh7F, 8'sh75, 8'sh5A, 8'sh31, 8'sh00, -8'sh31, -8'sh5A, -8'sh75,
    -8'sh7F, -8'sh75, -8'sh5A, -8'sh31, 8'sh00, 8'sh31, 8'sh5A, 8'sh75};
  logic [3:0] ph_r;
  logic signed [AW-1:0] re_r;
  logic signed [AW-1:0] im_r;
  logic signed [AW-1:0] re_nxt;
  logic signed [AW-1:0] im_nxt;
  logic [AW-1:0] a;
  logic [AW-1:0] b;
  logic [AW-1:0] m;

  function automatic logic [AW-1:0] absv(input logic signed [AW-1:0] v);
    return v < 0 ? AW'(-v) : AW'(v);
  endfunction

  always_comb begin
    re_nxt = re_r + AW'(x_i * COS_T[ph_r]);
    im_nxt = im_r + AW'(x_i * COS_T[4'(ph_r + 4'hC)]);
    a = absv(re_nxt);
    b = absv(im_nxt);
    m = (a > b) ? a + (b >> 1) : b + (a >> 1);
  end

  always_ff @(posedge clk_i or posedge rst_i) begin
    if (rst_i) begin
      ph_r <= '0;
      re_r <= '0;
      im_r <= '0;
      mag_o <= '0;
    end else if (stb_i) begin
      ph_r <= ph_r + 4'h1;
      if (ph_r == 4'hF) begin
        re_r <= '0;
        im_r <= '0;
        mag_o <= m[W+DFT_SHIFT-1:DFT_SHIFT];
      end else begin
        re_r <= re_nxt;
        im_r <= im_nxt;
      end
    end
  end
endmodule

// ---- efst_stage.sv ----
// One earth-fault stage: start comparison, delay accumulator and trip.
`timescale 1ns/10ps
module efst_stage
  import efst_pkg::*;
#(
  parameter bit INV_OK = 1'b0
) (
  input wire logic clk_i,
  input wire logic rst_i,
  input wire logic tick_i,
  input wire efst_set_t set_i,
  input wire logic [MW-1:0] mag_i,
  input wire logic peak_hit_i,
  input wire logic block_i,
  input wire logic force_i,
  input wire logic fstart_i,
  input wire logic ftrip_i,
  output efst_stat_t stat_o
);
  logic pk_seen_r;
  logic [31:0] acc_r;
  logic [15:0] gap_r;
  logic start;
  logic inv;
  logic [31:0] rate;
  logic [31:0] target;
  logic [31:0] rem;
  logic trip;
  int sh;

  always_comb begin
    inv = INV_OK & set_i.inverse;
    start = set_i.peak ? (pk_seen_r | peak_hit_i) : (mag_i > MW'(set_i.pickup));
    rate = inv ? 32'(mag_i - MW'(set_i.pickup)) : 32'h0000_0001;
    target = inv ? 32'(set_i.delay) * 32'(set_i.pickup) : 32'(set_i.delay);
    trip = start & ~block_i & (acc_r >= target);
    rem = (target > acc_r) ? target - acc_r : '0;
    sh = 0;
    for (int i = 0; i < 32; i++) begin
      if (rate[i]) begin
        sh = i;
      end
    end
  end

  // ==========================================================================
  // Accumulator runs in milliseconds; the intermittent gap keeps it alive.
  // ==========================================================================
  always_ff @(posedge clk_i or posedge rst_i) begin
    if (rst_i) begin
      pk_seen_r <= 1'b0;
      acc_r <= '0;
      gap_r <= '0;
    end else begin
      pk_seen_r <= tick_i ? 1'b0 : (pk_seen_r | peak_hit_i);
      if (start) begin
        gap_r <= '0;
        if (tick_i) begin
          acc_r <= acc_r + (set_i.peak ? PEAK_STEP_MS : rate);
        end
      end else if (gap_r >= set_i.intrmt) begin
        acc_r <= '0;
      end else if (tick_i) begin
        gap_r <= gap_r + 16'h0001;
      end
    end
  end

  always_ff @(posedge clk_i or posedge rst_i) begin
    if (rst_i) begin
      stat_o <= '{1'b0, 1'b0, ST_IDLE, 32'h0000_0000};
    end else if (force_i) begin
      stat_o.start <= fstart_i;
      stat_o.trip <= ftrip_i;
      stat_o.state <= ftrip_i ? ST_TRIPPED : (fstart_i ? ST_STARTED : ST_IDLE);
      stat_o.remain <= '0;
    end else begin
      stat_o.start <= start;
      stat_o.trip <= trip;
      stat_o.state <= block_i ? ST_BLOCKED :
                      (trip ? ST_TRIPPED : (start ? ST_STARTED : ST_IDLE));
      stat_o.remain <= start ? (inv ? rem >> sh : rem) : '0;
    end
  end
endmodule

// ---- efst_top.sv ----
// Four-stage undirectional earth-fault protection with its register port.
// Overview of operation
// - A stage starts while its selected fundamental residual exceeds its pick-up.
// - A stage trips once its start has persisted beyond its operation delay.
// - Fundamental extraction rejects the third harmonic by over 50 dB.
// - Each stage selects channel one, channel two or either summed residual.
// - Each summed residual adds the three phase currents of its own set.
// - Only stage one may also use peak values of the two residual channels.
// - A new start inside the intermittent time keeps the delay accumulator.
// - A one-millisecond peak starts the stage and adds 20 ms of delay.
// - Four stages; stage one offers inverse delay, the others definite only.
// - Definite delay at its minimum trips essentially at once.
// - Inverse delay shortens as current over pick-up grows.
// - Measurements clip at ten times residual and fifty times phase rating.
// - Two setting groups per stage, chosen manually or by a selected signal.
// - Status reads idle, blocked, started or tripped; start and trip tallies clear.
// - One shared force flag allows forcing start and trip; it expires after 5 minutes.
// - Fixed delay applies in definite mode; a multiplier scales the inverse curve.
// - A started stage reports its estimated remaining time to trip.
// - Pick-up is also reported in primary amperes.
`timescale 1ns/10ps
module efst_top
  import efst_pkg::*;
#(
  parameter int TICK_CYCLES = TICK_CYC,
  parameter logic [15:0] RES_RATED = 16'h03E8,
  parameter logic [15:0] PH_RATED = 16'h01F4
) (
  input wire logic CLK_I,
  input wire logic RESET_I,
  input wire logic [8:0] ADDR_I,
  input wire logic [31:0] WDATA_I,
  input wire logic WR_I,
  input wire logic RD_I,
  output logic [31:0] RDATA_O,
  input wire logic SAMPLE_STB_I,
  input wire logic signed [SW-1:0] RES1_I,
  input wire logic signed [SW-1:0] RES2_I,
  input wire logic signed [SW-1:0] PH_A_I,
  input wire logic signed [SW-1:0] PH_B_I,
  input wire logic signed [SW-1:0] PH_C_I,
  input wire logic signed [SW-1:0] PH2_A_I,
  input wire logic signed [SW-1:0] PH2_B_I,
  input wire logic signed [SW-1:0] PH2_C_I,
  input wire logic [NSTG-1:0] BLOCK_I,
  input wire logic [7:0] GRP_DI_I,
  input wire logic [7:0] GRP_VI_I,
  input wire logic [7:0] GRP_LED_I,
  input wire logic [7:0] GRP_VO_I,
  output logic [NSTG-1:0] START_O,
  output logic [NSTG-1:0] TRIP_O,
  output logic FORCE_O
);
  // ==========================================================================
  // Declarations
  // ==========================================================================
  localparam logic signed [MW-1:0] RES_LIM = MW'(RES_SAT_X * int'(RES_RATED));
  localparam logic signed [MW-1:0] PH_LIM = MW'(PH_SAT_X * int'(PH_RATED));
  logic [31:0] tick_cnt_r;
  logic tick;
  logic signed [MW-1:0] res1;
  logic signed [MW-1:0] res2;
  logic signed [MW-1:0] calc1;
  logic signed [MW-1:0] calc2;
  logic [MW-1:0] mag [4];
  logic [MW-1:0] pk1_r;
  logic [MW-1:0] pk2_r;
  logic [2:0] src_r [NSTG];
  logic inv_r [NSTG];
  logic [15:0] pick_r [NSTG][2];
  logic [15:0] dly_r [NSTG][2];
  logic [15:0] intrmt_r [NSTG];
  logic man_grp_r [NSTG];
  logic [2:0] grp_kind_r [NSTG];
  logic [2:0] grp_idx_r [NSTG];
  logic [1:0] fbits_r [NSTG];
  logic [31:0] stally_r [NSTG];
  logic [31:0] ttally_r [NSTG];
  logic [15:0] ratio_res_r;
  logic [15:0] ratio_ph_r;
  logic force_r;
  logic [31:0] force_cnt_r;
  logic grp [NSTG];
  efst_set_t set [NSTG];
  efst_stat_t stat [NSTG];
  efst_stat_t stat_q_r [NSTG];
  logic [MW-1:0] smag [NSTG];
  logic [31:0] prim [NSTG];
  logic pk_hit;
  logic [1:0] sel;
  logic [3:0] ix;
  logic glob;

  // Clips a signed value symmetrically at the given limit.
  function automatic logic signed [MW-1:0] clip(input logic signed [MW-1:0] v,
                                                input logic signed [MW-1:0] lim);
    if (v > lim) begin
      return lim;
    end else if (v < -lim) begin
      return -lim;
    end
    return v;
  endfunction

  function automatic logic [MW-1:0] absm(input logic signed [MW-1:0] v);
    return v < 0 ? MW'(-v) : MW'(v);
  endfunction

  // ==========================================================================
  // Millisecond timebase
  // ==========================================================================
  always_ff @(posedge CLK_I or posedge RESET_I) begin
    if (RESET_I) begin
      tick_cnt_r <= '0;
    end else if (tick_cnt_r == 32'(TICK_CYCLES - 1)) begin
      tick_cnt_r <= '0;
    end else begin
      tick_cnt_r <= tick_cnt_r + 32'h0000_0001;
    end
  end
  assign tick = (tick_cnt_r == 32'(TICK_CYCLES - 1));

  // ==========================================================================
  // Measurement conditioning
  // ==========================================================================
  // Clipping before the sum models the finite range of each analogue front end.
  always_comb begin
    res1 = clip(MW'(RES1_I), RES_LIM);
    res2 = clip(MW'(RES2_I), RES_LIM);
    calc1 = clip(MW'(PH_A_I), PH_LIM) + clip(MW'(PH_B_I), PH_LIM)
          + clip(MW'(PH_C_I), PH_LIM);
    calc2 = clip(MW'(PH2_A_I), PH_LIM) + clip(MW'(PH2_B_I), PH_LIM)
          + clip(MW'(PH2_C_I), PH_LIM);
  end

  efst_fund #(.W(MW)) u_fund_r1 (
    .clk_i(CLK_I), .rst_i(RESET_I), .stb_i(SAMPLE_STB_I), .x_i(res1), .mag_o(mag[0]));
  efst_fund #(.W(MW)) u_fund_r2 (
    .clk_i(CLK_I), .rst_i(RESET_I), .stb_i(SAMPLE_STB_I), .x_i(res2), .mag_o(mag[1]));
  efst_fund #(.W(MW)) u_fund_c1 (
    .clk_i(CLK_I), .rst_i(RESET_I), .stb_i(SAMPLE_STB_I), .x_i(calc1), .mag_o(mag[2]));
  efst_fund #(.W(MW)) u_fund_c2 (
    .clk_i(CLK_I), .rst_i(RESET_I), .stb_i(SAMPLE_STB_I), .x_i(calc2), .mag_o(mag[3]));

  // Peak values are the absolute values of the clipped samples, registered once.
  always_ff @(posedge CLK_I or posedge RESET_I) begin
    if (RESET_I) begin
      pk1_r <= '0;
      pk2_r <= '0;
    end else if (SAMPLE_STB_I) begin
      pk1_r <= absm(res1);
      pk2_r <= absm(res2);
    end
  end

  // ==========================================================================
  // Per-stage setting selection
  // ==========================================================================
  always_comb begin
    pk_hit = 1'b0;
    for (int s = 0; s < NSTG; s++) begin
      unique case (grp_kind_r[s])
        3'd1: grp[s] = GRP_DI_I[grp_idx_r[s]];
        3'd2: grp[s] = GRP_VI_I[grp_idx_r[s]];
        3'd3: grp[s] = GRP_LED_I[grp_idx_r[s]];
        3'd4: grp[s] = GRP_VO_I[grp_idx_r[s]];
        default: grp[s] = man_grp_r[s];
      endcase
      // Stages two to four see only the four fundamental sources.
      smag[s] = mag[src_r[s][1:0]];
      set[s].peak = (s == 0) && src_r[s][2];
      set[s].inverse = (s == 0) && inv_r[s];
      set[s].pickup = pick_r[s][grp[s]];
      set[s].delay = dly_r[s][grp[s]];
      set[s].intrmt = intrmt_r[s];
      prim[s] = 32'(set[s].pickup) * 32'(src_r[s][1] ? ratio_ph_r : ratio_res_r);
    end
    if (src_r[0] == SRC_PK1) begin
      pk_hit = SAMPLE_STB_I && (pk1_r > MW'(set[0].pickup));
    end else if (src_r[0] == SRC_PK2) begin
      pk_hit = SAMPLE_STB_I && (pk2_r > MW'(set[0].pickup));
    end
  end

  // ==========================================================================
  // Stages
  // ==========================================================================
  efst_stage #(.INV_OK(1'b1)) u_stage0 (
    .clk_i(CLK_I), .rst_i(RESET_I), .tick_i(tick), .set_i(set[0]), .mag_i(smag[0]),
    .peak_hit_i(pk_hit), .block_i(BLOCK_I[0]), .force_i(force_r),
    .fstart_i(fbits_r[0][0]), .ftrip_i(fbits_r[0][1]), .stat_o(stat[0]));

  generate
    for (genvar g = 1; g < NSTG; g++) begin : g_dt
      efst_stage #(.INV_OK(1'b0)) u_stage (
        .clk_i(CLK_I), .rst_i(RESET_I), .tick_i(tick), .set_i(set[g]), .mag_i(smag[g]),
        .peak_hit_i(1'b0), .block_i(BLOCK_I[g]), .force_i(force_r),
        .fstart_i(fbits_r[g][0]), .ftrip_i(fbits_r[g][1]), .stat_o(stat[g]));
    end
  endgenerate

  always_comb begin
    for (int s = 0; s < NSTG; s++) begin
      START_O[s] = stat[s].start;
      TRIP_O[s] = stat[s].trip;
    end
  end
  assign FORCE_O = force_r;

  // ==========================================================================
  // Register writes
  // ==========================================================================
  assign sel = ADDR_I[7:6];
  assign ix = ADDR_I[5:2];
  assign glob = ADDR_I[8];

  always_ff @(posedge CLK_I or posedge RESET_I) begin
    if (RESET_I) begin
      for (int s = 0; s < NSTG; s++) begin
        src_r[s] <= SRC_CH1;
        inv_r[s] <= 1'b0;
        pick_r[s][0] <= PICK_RST;
        pick_r[s][1] <= PICK_RST;
        dly_r[s][0] <= DLY_RST;
        dly_r[s][1] <= DLY_RST;
        intrmt_r[s] <= '0;
        man_grp_r[s] <= 1'b0;
        grp_kind_r[s] <= '0;
        grp_idx_r[s] <= '0;
      end
      ratio_res_r <= RATIO_RST;
      ratio_ph_r <= RATIO_RST;
    end else if (WR_I && glob) begin
      if (ix == IX_GRATIO_RES) begin
        ratio_res_r <= WDATA_I[15:0];
      end
      if (ix == IX_GRATIO_PH) begin
        ratio_ph_r <= WDATA_I[15:0];
      end
    end else if (WR_I) begin
      unique case (ix)
        IX_CTRL: begin
          inv_r[sel] <= WDATA_I[0];
          // Peak sources are refused on stages that cannot use them.
          src_r[sel] <= (sel != 2'd0) ? {1'b0, WDATA_I[2:1]} : WDATA_I[3:1];
        end
        IX_PICK1: pick_r[sel][0] <= WDATA_I[15:0];
        IX_DLY1: dly_r[sel][0] <= WDATA_I[15:0];
        IX_PICK2: pick_r[sel][1] <= WDATA_I[15:0];
        IX_DLY2: dly_r[sel][1] <= WDATA_I[15:0];
        IX_INTRMT: intrmt_r[sel] <= WDATA_I[15:0];
        IX_GROUP: begin
          man_grp_r[sel] <= WDATA_I[0];
          grp_kind_r[sel] <= WDATA_I[3:1];
          grp_idx_r[sel] <= WDATA_I[6:4];
        end
        default: begin
        end
      endcase
    end
  end

  // ==========================================================================
  // Shared force flag with its timeout
  // ==========================================================================
  always_ff @(posedge CLK_I or posedge RESET_I) begin
    if (RESET_I) begin
      force_r <= 1'b0;
      force_cnt_r <= '0;
      for (int s = 0; s < NSTG; s++) begin
        fbits_r[s] <= '0;
      end
    end else begin
      if (WR_I && glob && ix == IX_GFORCE) begin
        force_r <= WDATA_I[0];
        force_cnt_r <= '0;
      end else if (force_r && tick) begin
        if (force_cnt_r >= FORCE_TIMEOUT_MS - 32'h0000_0001) begin
          force_r <= 1'b0;
        end
        force_cnt_r <= force_cnt_r + 32'h0000_0001;
      end
      // Forced states are editable only while the flag is on.
      if (WR_I && !glob && ix == IX_FSTAT && force_r) begin
        fbits_r[sel] <= WDATA_I[1:0];
      end
    end
  end

  // ==========================================================================
  // Cumulative tallies; an edge in the clearing cycle still counts
  // ==========================================================================
  always_ff @(posedge CLK_I or posedge RESET_I) begin
    if (RESET_I) begin
      for (int s = 0; s < NSTG; s++) begin
        stally_r[s] <= '0;
        ttally_r[s] <= '0;
        stat_q_r[s] <= '0;
      end
    end else begin
      for (int s = 0; s < NSTG; s++) begin
        logic sinc;
        logic tinc;
        logic sclr;
        logic tclr;
        sinc = stat[s].start & ~stat_q_r[s].start;
        tinc = stat[s].trip & ~stat_q_r[s].trip;
        sclr = WR_I && !glob && sel == 2'(s) && ix == IX_STALLY;
        tclr = WR_I && !glob && sel == 2'(s) && ix == IX_TTALLY;
        stat_q_r[s] <= stat[s];
        if (sclr) begin
          stally_r[s] <= 32'(sinc);
        end else if (sinc) begin
          stally_r[s] <= stally_r[s] + 32'h0000_0001;
        end
        if (tclr) begin
          ttally_r[s] <= 32'(tinc);
        end else if (tinc) begin
          ttally_r[s] <= ttally_r[s] + 32'h0000_0001;
        end
      end
    end
  end

  // ==========================================================================
  // Register reads, answered in the following cycle
  // ==========================================================================
  always_ff @(posedge CLK_I or posedge RESET_I) begin
    if (RESET_I) begin
      RDATA_O <= '0;
    end else if (RD_I && glob) begin
      unique case (ix)
        IX_GFORCE: RDATA_O <= {31'h0000_0000, force_r};
        IX_GRATIO_RES: RDATA_O <= {16'h0000, ratio_res_r};
        IX_GRATIO_PH: RDATA_O <= {16'h0000, ratio_ph_r};
        default: RDATA_O <= '0;
      endcase
    end else if (RD_I) begin
      unique case (ix)
        IX_CTRL: RDATA_O <= {28'h000_0000, src_r[sel], inv_r[sel]};
        IX_PICK1: RDATA_O <= {16'h0000, pick_r[sel][0]};
        IX_DLY1: RDATA_O <= {16'h0000, dly_r[sel][0]};
        IX_PICK2: RDATA_O <= {16'h0000, pick_r[sel][1]};
        IX_DLY2: RDATA_O <= {16'h0000, dly_r[sel][1]};
        IX_INTRMT: RDATA_O <= {16'h0000, intrmt_r[sel]};
        IX_STATUS: RDATA_O <= {27'h000_0000, grp[sel], stat[sel].trip, stat[sel].start,
                               stat[sel].state};
        IX_REMAIN: RDATA_O <= stat[sel].remain;
        IX_STALLY: RDATA_O <= stally_r[sel];
        IX_TTALLY: RDATA_O <= ttally_r[sel];
        IX_PRIM: RDATA_O <= prim[sel];
        IX_GROUP: RDATA_O <= {25'h000_0000, grp_idx_r[sel], grp_kind_r[sel], man_grp_r[sel]};
        IX_FSTAT: RDATA_O <= {30'h0000_0000, fbits_r[sel]};
        default: RDATA_O <= '0;
      endcase
    end else begin
      RDATA_O <= '0;
    end
  end
endmodule

// ---- efst_chk.sv ----
// Port checker for the earth-fault stage timer, bound to the top module.
`timescale 1ns/10ps
module efst_chk
  import efst_pkg::*;
(
  input wire logic CLK_I,
  input wire logic RESET_I,
  input wire logic [8:0] ADDR_I,
  input wire logic [31:0] WDATA_I,
  input wire logic WR_I,
  input wire logic RD_I,
  input wire logic [31:0] RDATA_O,
  input wire logic [NSTG-1:0] BLOCK_I,
  input wire logic [NSTG-1:0] START_O,
  input wire logic [NSTG-1:0] TRIP_O,
  input wire logic FORCE_O
);
  // ==========
  // Properties
  default clocking @(posedge CLK_I); endclocking
  default disable iff (RESET_I);
  logic frc_r;
  logic calm;
  // Forced states may legally break the normal start and trip relations.
  always_ff @(posedge CLK_I or posedge RESET_I) begin
    if (RESET_I) frc_r <= 1'b0;
    else frc_r <= FORCE_O;
  end
  assign calm = !FORCE_O && !frc_r;
  rd_idle_a: assert property (!RD_I |=> RDATA_O == 32'h0000_0000)
    else $error("read data not idle");
  trip_start_a: assert property (!calm || !(|(TRIP_O & ~START_O)))
    else $error("trip without start");
  blk_trip_a: assert property (BLOCK_I[0] && $past(BLOCK_I[0]) && calm |-> !TRIP_O[0])
    else $error("trip while blocked");
  frc_set_a: assert property (WR_I && ADDR_I == 9'h100 |=>
    FORCE_O == $past(WDATA_I[0])) else $error("force flag not written");
  frc_rise_a: assert property ($rose(FORCE_O) |->
    $past(WR_I) && $past(ADDR_I) == 9'h100) else $error("force flag rose by itself");
  start_drop_a: assert property ($fell(START_O[0]) && calm |-> !TRIP_O[0])
    else $error("trip outlived start");
  trip_hold_a: assert property (TRIP_O[0] && calm && !BLOCK_I[0]
    ##1 START_O[0] && !BLOCK_I[0] && calm |-> TRIP_O[0]) else $error("trip dropped early");
  trip_late_a: assert property ($rose(TRIP_O[1]) && calm |-> $past(START_O[1], 8))
    else $error("trip came before its delay");
  cover property (TRIP_O[0] && START_O[0]);
  cover property (BLOCK_I[0] && START_O[0]);
  cover property (FORCE_O && TRIP_O[2]);
endmodule
bind efst_top efst_chk chk_u (.CLK_I(CLK_I), .RESET_I(RESET_I), .ADDR_I(ADDR_I),
  .WDATA_I(WDATA_I), .WR_I(WR_I), .RD_I(RD_I), .RDATA_O(RDATA_O), .BLOCK_I(BLOCK_I),
  .START_O(START_O), .TRIP_O(TRIP_O), .FORCE_O(FORCE_O));

// ---- efst_feed.sv ----
// Behavioural model of the residual and phase current channels.
`timescale 1ns/10ps
module efst_feed
  import efst_pkg::*;
(
  input wire logic clk_i,
  input wire logic [15:0] amp1_i,
  input wire logic [15:0] amp2_i,
  output logic stb_o,
  output logic signed [SW-1:0] res1_o,
  output logic signed [SW-1:0] res2_o,
  output logic signed [SW-1:0] ph_o
);
  // ==========
  // Sampling
  logic [1:0] div_r = 2'h0;
  logic [3:0] k_r = 4'h0;
  function automatic logic signed [SW-1:0] wave(input logic [15:0] a, input logic [3:0] n);
    return SW'($rtoi(real'(a) * $sin(6.283185 * real'(n) / 16.0)));
  endfunction
  // Sixteen strobes per mains cycle, one every fourth clock.
  always @(posedge clk_i) begin
    div_r <= div_r + 2'h1;
    stb_o <= (div_r == 2'h3);
    if (div_r == 2'h3) begin
      k_r <= k_r + 4'h1;
      res1_o <= wave(amp1_i, k_r);
      res2_o <= wave(amp2_i, k_r);
      ph_o <= wave(amp2_i, k_r + 4'h4);
    end
  end
endmodule

// ---- tb.sv ----
// Self-checking bench for the earth-fault stage timer.
`timescale 1ns/10ps
module tb;
  import efst_pkg::*;
  logic clk = 1'b0, rst = 1'b1, wr = 1'b0, rd = 1'b0, stb, frc;
  logic [8:0] addr = 9'h000;
  logic [31:0] wdata = 32'h0000_0000, rdata;
  logic [3:0] blk = 4'h0, st, tr;
  logic [15:0] a1 = 16'h0000, a2 = 16'h0000;
  logic [7:0] di = 8'h00;
  logic signed [SW-1:0] r1, r2, ph;
  int err_count = 0, check_count = 0, n;
  // ==========
  // Harness
  initial begin
    forever #12.5 clk = ~clk;
  end
  efst_feed feed_u (.clk_i(clk), .amp1_i(a1), .amp2_i(a2), .stb_o(stb), .res1_o(r1),
    .res2_o(r2), .ph_o(ph));
  efst_top #(.TICK_CYCLES(10)) dut_u (.CLK_I(clk), .RESET_I(rst), .ADDR_I(addr),
    .WDATA_I(wdata), .WR_I(wr), .RD_I(rd), .RDATA_O(rdata), .SAMPLE_STB_I(stb), .RES1_I(r1),
    .RES2_I(r2), .PH_A_I(ph), .PH_B_I(ph), .PH_C_I(ph), .PH2_A_I(ph), .PH2_B_I(ph),
    .PH2_C_I(ph), .BLOCK_I(blk), .GRP_DI_I(di), .GRP_VI_I(8'h00), .GRP_LED_I(8'h00),
    .GRP_VO_I(8'h00), .START_O(st), .TRIP_O(tr), .FORCE_O(frc));
  task automatic end_sim;
    if (err_count == 0 && check_count > 0) $display("TB: PASS");
    else $display("TB: FAIL");
    $finish;
  endtask
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    check_count++;
    if (got !== exp) begin
      err_count++;
      $display("unexpected at %0t: got %h exp %h", $time, got, exp);
    end
  endtask
  task automatic wreg(input logic [8:0] a, input logic [31:0] d);
    wr <= 1'b1;
    addr <= a;
    wdata <= d;
    @(posedge clk);
    wr <= 1'b0;
    @(posedge clk);
  endtask
  task automatic rreg(input logic [8:0] a, input logic [31:0] exp);
    rd <= 1'b1;
    addr <= a;
    @(posedge clk);
    rd <= 1'b0;
    #1 chk(rdata, exp);
    @(posedge clk);
  endtask
  // Waits until the masked start or trip vector equals v; a timeout ends the run.
  task automatic wait_for(input bit t, input logic [3:0] m, input logic [3:0] v, input int lim);
    n = 0;
    while (((t ? tr : st) & m) !== v && n < lim) begin
      @(posedge clk);
      #1;
      n++;
    end
    if (n >= lim) begin
      chk(32'(n), 32'h0000_0000);
      end_sim();
    end
  endtask
  // ==========
  // Scenarios
  initial begin
    repeat (4) @(posedge clk);
    rst <= 1'b0;
    @(posedge clk);
    rreg(9'h004, 32'h0000_FFFF);
    rreg(9'h008, 32'h0000_0064);
    rreg(9'h03C, 32'h0000_0000);
    wreg(9'h004, 32'h0000_03E8);
    wreg(9'h008, 32'h0000_0000);
    a1 <= 16'h0BB8;
    wait_for(0, 4'h1, 4'h1, 400);
    chk(32'(tr), 32'h0000_0001);
    rreg(9'h018, 32'h0000_000F);
    rreg(9'h020, 32'h0000_0001);
    rreg(9'h028, 32'h0000_03E8);
    wreg(9'h040, 32'h0000_0008);
    rreg(9'h040, 32'h0000_0000);
    blk <= 4'h1;
    repeat (2) @(posedge clk);
    #1 chk(32'(tr), 32'h0000_0000);
    rreg(9'h018, 32'h0000_0005);
    blk <= 4'h0;
    wreg(9'h040, 32'h0000_0002);
    wreg(9'h044, 32'h0000_03E8);
    wreg(9'h048, 32'h0000_0005);
    a2 <= 16'h0BB8;
    wait_for(0, 4'h2, 4'h2, 400);
    wait_for(1, 4'h2, 4'h2, 100);
    chk(32'(n >= 40 && n <= 60), 32'h0000_0001);
    a1 <= 16'h0000;
    a2 <= 16'h0000;
    wait_for(0, 4'h3, 4'h0, 400);
    chk(32'(tr), 32'h0000_0000);
    rreg(9'h064, 32'h0000_0001);
    wreg(9'h0B0, 32'h0000_0003);
    chk(32'(st), 32'h0000_0000);
    wreg(9'h100, 32'h0000_0001);
    chk(32'(frc), 32'h0000_0001);
    rreg(9'h0B0, 32'h0000_0000);
    wreg(9'h0B0, 32'h0000_0003);
    wait_for(1, 4'h4, 4'h4, 5);
    wreg(9'h100, 32'h0000_0000);
    chk(32'(frc), 32'h0000_0000);
    wreg(9'h020, 32'h0000_0000);
    rreg(9'h020, 32'h0000_0000);
    wreg(9'h02C, 32'h0000_0012);
    di <= 8'h02;
    rreg(9'h018, 32'h0000_0010);
    end_sim();
  end
endmodule
